// ---- logic/subsystem_bus_port.sv ----
// subsystem parallel port: strobe decode, address latch, attribute memory, event flags
// assumes pins arrive asynchronously; host port writes arrive on clk_sys as pulses
`timescale 1ns/1ps
// Overview of operation
// - mode high: low lines address, shared bus data
// - mode low: shared bus multiplexes address/data
// - high address bit is address bit 8
// - shared bus reaches ram and config registers
// - style 1 data strobe, 0 separate strobes
// - write pin: write strobe or direction
// - open-drain status change after subsystem writes to ram or config registers
// - read pin: read enable or data strobe
// - interrupt to subsystem on host writes
// - latch strobe captures multiplexed address
module subsystem_bus_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // subsystem pins
  input wire logic addr_mode_select,
  input wire logic bus_style_select,
  input wire logic [7:0] low_address_lines,
  input wire logic high_address_bit,
  input wire logic address_latch_strobe,
  input wire logic read_or_data_strobe_n,
  input wire logic write_or_direction,
  input wire logic [7:0] shared_addr_data_in,
  output logic [7:0] shared_addr_data_out,
  output logic shared_addr_data_oe_n,
  // host side events and acknowledges
  input wire logic host_write_pulse,
  input wire logic host_irq_ack,
  input wire logic status_change_ack,
  // event outputs
  output logic subsystem_irq,
  output logic status_change_out_o,
  output logic status_change_out_oe_n
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // 1 + 1 + 8 + 1 + 1 + 1 + 1 + 8 pin bits
  localparam int NSYNC = 22;
  logic [NSYNC-1:0] pin_raw, sync1_reg, sync2_reg;
  assign pin_raw = {addr_mode_select, bus_style_select, low_address_lines,
                    high_address_bit, address_latch_strobe, read_or_data_strobe_n,
                    write_or_direction, shared_addr_data_in};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  logic mode_s, style_s, hab_s, ale_s, rds_n_s, wrd_s;
  logic [7:0] low_s, sad_s;
  assign {mode_s, style_s, low_s, hab_s, ale_s, rds_n_s, wrd_s, sad_s} = sync2_reg;

  ////////////////////////////////////////////////////////////////////
  // strobe decode
  function automatic subsystem_bus_port_pkg::access_e decode(
    input logic style, input logic rds_n, input logic wrd);
    if (style == subsystem_bus_port_pkg::STYLE_DS) begin
      if (rds_n) decode = subsystem_bus_port_pkg::ST_IDLE;
      else if (wrd) decode = subsystem_bus_port_pkg::ST_READ;
      else decode = subsystem_bus_port_pkg::ST_WRITE;
    end else begin
      if (!rds_n && wrd) decode = subsystem_bus_port_pkg::ST_READ;
      else if (rds_n && !wrd) decode = subsystem_bus_port_pkg::ST_WRITE;
      else decode = subsystem_bus_port_pkg::ST_IDLE;
    end
  endfunction

  subsystem_bus_port_pkg::access_e acc, acc_reg, acc_next;
  assign acc = decode(style_s, rds_n_s, wrd_s);

  ////////////////////////////////////////////////////////////////////
  // address latch and effective address
  logic [7:0] alat_reg, alat_next;
  logic ale_active;
  logic [8:0] eff_addr;
  always_comb begin
    ale_active = (style_s == subsystem_bus_port_pkg::STYLE_DS) ? !ale_s : ale_s;
    alat_next = alat_reg;
    // capture shared lines while strobe active in multiplexed mode (mode low)
    if (!mode_s && ale_active) alat_next = sad_s;
    eff_addr = mode_s ? {hab_s, low_s} : {hab_s, alat_reg};
  end

  ////////////////////////////////////////////////////////////////////
  // attribute memory
  logic [7:0] ram [subsystem_bus_port_pkg::RAM_DEPTH];
  logic [7:0] cfg_reg [subsystem_bus_port_pkg::CFG_COUNT];
  logic write_start, read_start;
  logic in_ram, in_cfg;
  logic [2:0] cfg_idx;
  logic [7:0] rd_data;
  always_comb begin
    write_start = (acc == subsystem_bus_port_pkg::ST_WRITE) &&
                  (acc_reg != subsystem_bus_port_pkg::ST_WRITE);
    read_start = (acc == subsystem_bus_port_pkg::ST_READ);
    in_ram = !eff_addr[8];
    in_cfg = (eff_addr >= subsystem_bus_port_pkg::CFG_BASE) &&
             (eff_addr < subsystem_bus_port_pkg::CFG_BASE +
                         9'(subsystem_bus_port_pkg::CFG_COUNT));
    cfg_idx = eff_addr[2:0];
    acc_next = acc;
    // read path from ram or config registers
    if (in_ram) rd_data = ram[eff_addr[7:0]];
    else if (in_cfg) rd_data = cfg_reg[cfg_idx];
    else rd_data = subsystem_bus_port_pkg::IDLE_READ;
  end

  // write path into ram and config registers
  always_ff @(posedge clk_sys) begin
    if (write_start && in_ram) ram[eff_addr[7:0]] <= sad_s;
  end
  genvar gi;
  generate
    for (gi = 0; gi < subsystem_bus_port_pkg::CFG_COUNT; gi++) begin : g_cfg
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) cfg_reg[gi] <= subsystem_bus_port_pkg::CFG_RESET;
        else if (write_start && in_cfg && cfg_idx == 3'(gi)) cfg_reg[gi] <= sad_s;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // bus drive and event flags
  logic [7:0] dout_reg, dout_next;
  logic oe_n_reg, oe_n_next, irq_reg, irq_next, stc_n_reg, stc_n_next;
  always_comb begin
    dout_next = read_start ? rd_data : dout_reg;
    oe_n_next = !read_start;
    // host write sets, set wins over ack
    irq_next = host_write_pulse ? 1'b1 : (host_irq_ack ? 1'b0 : irq_reg);
    // subsystem write to ram or config registers sets, set wins over ack
    stc_n_next = (write_start && (in_ram || in_cfg)) ? 1'b0 :
                 (status_change_ack ? 1'b1 : stc_n_reg);
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= subsystem_bus_port_pkg::ST_IDLE;
      alat_reg <= '0;
      dout_reg <= '0;
      oe_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      stc_n_reg <= 1'b1;
    end else begin
      acc_reg <= acc_next;
      alat_reg <= alat_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      irq_reg <= irq_next;
      stc_n_reg <= stc_n_next;
    end
  end
  assign shared_addr_data_out = dout_reg;
  assign shared_addr_data_oe_n = oe_n_reg;
  assign subsystem_irq = irq_reg;
  // open drain: drives low only while flag set
  assign status_change_out_o = 1'b0;
  assign status_change_out_oe_n = stc_n_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sub_write;
    write_start && (in_ram || in_cfg);
  endsequence
  a_status_on_write:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      s_sub_write |=> !status_change_out_oe_n) else $error("status change not driven");
  a_irq_on_host:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      host_write_pulse |=> subsystem_irq) else $error("irq missed host write");
  a_irq_holds:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      subsystem_irq && !host_irq_ack |=> subsystem_irq) else $error("irq dropped");
  a_read_drives:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      read_start |=> !shared_addr_data_oe_n && shared_addr_data_out == $past(rd_data))
      else $error("read data not driven");
  a_no_drive_idle:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      rds_n_s && style_s |=> shared_addr_data_oe_n) else $error("drive without strobe");
  a_sep_write:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !style_s && rds_n_s && !wrd_s |-> acc == subsystem_bus_port_pkg::ST_WRITE)
      else $error("separate write not decoded");
  a_ds_write:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      style_s && !rds_n_s && !wrd_s |-> acc == subsystem_bus_port_pkg::ST_WRITE)
      else $error("strobe write not decoded");
  a_latch_addr:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !mode_s && ale_active |=> alat_reg == $past(sad_s)) else $error("address not latched");
  a_direct_addr:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      mode_s |-> eff_addr == {hab_s, low_s}) else $error("direct address wrong");
  a_mux_addr:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !mode_s |-> eff_addr[7:0] == alat_reg) else $error("mux address wrong");
  a_bit8:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      eff_addr[8] == hab_s) else $error("bit 8 wrong");
  a_irq_ack_clears:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      host_irq_ack && !host_write_pulse |=> !subsystem_irq) else $error("irq not cleared");
  a_status_ack_clears:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      status_change_ack && !(write_start && (in_ram || in_cfg)) |=> status_change_out_oe_n)
      else $error("status change not released");
  a_sep_both_idle:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !style_s && (rds_n_s == wrd_s) |-> acc == subsystem_bus_port_pkg::ST_IDLE)
      else $error("separate strobes misdecoded");
  a_release_bus:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !read_start |=> shared_addr_data_oe_n) else $error("bus held without read");
  a_cfg_write:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      write_start && in_cfg |=> cfg_reg[$past(cfg_idx)] == $past(sad_s))
      else $error("config write lost");
endmodule

// ---- logic/subsystem_bus_port_pkg.sv ----
// constants for the subsystem-side parallel port into attribute memory
// assumes a single 200 MHz system clock; pins are synchronised inside the port
package subsystem_bus_port_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int RAM_DEPTH = 256;
  localparam int CFG_COUNT = 8;
  // card_config_regs sit at subsystem addresses 256..263
  localparam logic [8:0] CFG_BASE = 9'h100;
  localparam logic [7:0] RAM_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] IDLE_READ = 8'hff;
  // bus style encodings
  localparam logic STYLE_DS = 1'b1;
  localparam logic STYLE_RDWR = 1'b0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } access_e;
endpackage

// ---- testbench/subsystem_cpu_model.sv ----
// subsystem microcontroller model driving the port pins
// assumes pins change on falling clk_sys edges, bus level resolved outside
`timescale 1ns/1ps
module subsystem_cpu_model (
  // clock
  input wire logic clk_sys,
  // pins toward the port
  output logic addr_mode_select,
  output logic bus_style_select,
  output logic [7:0] low_address_lines,
  output logic high_address_bit,
  output logic address_latch_strobe,
  output logic read_or_data_strobe_n,
  output logic write_or_direction,
  // shared bus: own drive and resolved level
  output logic [7:0] bus_drive,
  output logic bus_en,
  input wire logic [7:0] bus_level
);
  initial begin
    addr_mode_select = 1'b1;
    bus_style_select = 1'b0;
    low_address_lines = 8'h00;
    high_address_bit = 1'b0;
    address_latch_strobe = 1'b0;
    read_or_data_strobe_n = 1'b1;
    write_or_direction = 1'b1;
    bus_drive = 8'h00;
    bus_en = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one byte access; low lines carry garbage in multiplexed mode
  task automatic xfer(input logic mux, input logic style, input logic wr,
                      input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    addr_mode_select = ~mux;
    bus_style_select = style;
    high_address_bit = a[8];
    low_address_lines = mux ? ~a[7:0] : a[7:0];
    bus_drive = a[7:0];
    bus_en = mux;
    address_latch_strobe = mux ^ style;
    repeat (4) @(negedge clk_sys);
    address_latch_strobe = style;
    repeat (3) @(negedge clk_sys);
    bus_drive = d;
    bus_en = wr;
    write_or_direction = ~wr;
    read_or_data_strobe_n = wr & ~style;
    repeat (6) @(negedge clk_sys);
    q = bus_level;
    read_or_data_strobe_n = 1'b1;
    write_or_direction = 1'b1;
    repeat (5) @(negedge clk_sys);
    bus_en = 1'b0;
  endtask
endmodule

// ---- testbench/test_subsystem_bus_port.sv ----
// self-checking bench for the subsystem parallel port
// assumes the cpu model drives every subsystem pin
`timescale 1ns/1ps
module test_subsystem_bus_port;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hwp = 1'b0;
  logic hack = 1'b0;
  logic sack = 1'b0;
  logic mode, style, lat, rds_n, wod, hib, en, oe_n, irq, sc_o, sc_oe_n;
  logic [7:0] low, drv, dout, level, q;
  int n_fail = 0;
  int checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  // released bus shows the inverse of the last drive
  assign level = !oe_n ? dout : (en ? drv : ~drv);
  subsystem_bus_port dut (.clk_sys(clk_sys), .nrst(nrst), .addr_mode_select(mode),
    .bus_style_select(style), .low_address_lines(low), .high_address_bit(hib),
    .address_latch_strobe(lat), .read_or_data_strobe_n(rds_n), .write_or_direction(wod),
    .shared_addr_data_in(level), .shared_addr_data_out(dout), .shared_addr_data_oe_n(oe_n),
    .host_write_pulse(hwp), .host_irq_ack(hack), .status_change_ack(sack),
    .subsystem_irq(irq), .status_change_out_o(sc_o), .status_change_out_oe_n(sc_oe_n));
  subsystem_cpu_model cpu (.clk_sys(clk_sys), .addr_mode_select(mode),
    .bus_style_select(style), .low_address_lines(low), .high_address_bit(hib),
    .address_latch_strobe(lat), .read_or_data_strobe_n(rds_n), .write_or_direction(wod),
    .bus_drive(drv), .bus_en(en), .bus_level(level));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      cpu.xfer(m[1], m[0], 1'b1, 9'h000 + 9'(m), 8'h5a ^ 8'(m), q);
      cpu.xfer(m[1], m[0], 1'b1, 9'h100 + 9'(m), 8'ha0 + 8'(m), q);
      cpu.xfer(m[1], m[0], 1'b0, 9'h000 + 9'(m), 8'h00, q);
      check("ram", q, 8'h5a ^ 8'(m));
      cpu.xfer(m[1], m[0], 1'b0, 9'h100 + 9'(m), 8'h00, q);
      check("cfg", q, 8'ha0 + 8'(m));
    end
    $display("t_modes done");
  endtask
  task automatic t_status;
    pulse(sack);
    cpu.xfer(1'b0, 1'b0, 1'b1, 9'h1ff, 8'h33, q);
    check("stat_idle", 8'(sc_oe_n), 8'h01);
    cpu.xfer(1'b0, 1'b1, 1'b0, 9'h1ff, 8'hff, q);
    check("unmapped", q, 8'hff);
    cpu.xfer(1'b1, 1'b1, 1'b1, 9'h0ff, 8'hc3, q);
    check("stat_set", 8'(sc_oe_n), 8'h00);
    check("stat_od", 8'(sc_o), 8'h00);
    pulse(sack);
    check("stat_ack", 8'(sc_oe_n), 8'h01);
    $display("t_status done");
  endtask
  task automatic t_irq;
    check("irq_idle", 8'(irq), 8'h00);
    pulse(hwp);
    check("irq_set", 8'(irq), 8'h01);
    pulse(hack);
    check("irq_ack", 8'(irq), 8'h00);
    // set and ack in one cycle: set wins
    @(negedge clk_sys);
    hwp = 1'b1;
    hack = 1'b1;
    @(negedge clk_sys);
    hwp = 1'b0;
    hack = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("irq_win", 8'(irq), 8'h01);
    pulse(hack);
    check("irq_clr", 8'(irq), 8'h00);
    $display("t_irq done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_irq();
    t_modes();
    t_status();
    finish_test();
  end
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule
